/* design/usb_cmd_pkg.sv */
// constants of the usb host command register block
// How it works
// - register block decoded in I/O space at a base from a configuration register.
// - 16-bit command register at offsets 0-1, read/write, reset to zero.
// - every write is a command, acted on at once.
// - bit 7 selects reclamation packet size, one 64 bytes, zero 32 bytes.
// - another transaction starts only if selected size fits remaining frame time; the code compares the reclaim_time_cost input, not the bit 7 size.
// - oversize reclamation packet in the end window flags babble, stalls endpoint.
// - bit 6 configured flag is stored and read back only.
// - debug mode clears run/stop after each transaction; waits for software.
// - while bit 4 is one, drive global resume on the bus, except during the EOP and the cycle after it.
// - in global suspend a connect, disconnect or K-state sets force resume.
// - force resume one-to-zero sends low-speed EOP; bit reads one until done.
// - while bit 3 is one, no transactions; resume still works.
// - bit 2 drives global reset on the bus; when it clears, resets the command register, halt, babble, stall and EOP logic.
// - run/stop executes schedule; on clear, halt in the next cycle without waiting for the transaction.
package usb_cmd_pkg;
    localparam int          IO_ADDR_W         = 16;
    localparam logic [15:0] CMD_OFFSET        = 16'h0000;
    localparam logic [15:0] CMD_RESET         = 16'h0000;
    localparam logic [15:0] CMD_WRITE_MASK    = 16'h00ff;
    localparam int          BIT_RECLAIM_SEL   = 7;
    localparam int          BIT_CONFIGURED    = 6;
    localparam int          BIT_SINGLE_STEP   = 5;
    localparam int          BIT_FORCE_RESUME  = 4;
    localparam int          BIT_SUSPEND       = 3;
    localparam int          BIT_BUS_RESET     = 2;
    localparam int          BIT_RUN_STOP      = 0;
    localparam int          CLK_HZ            = 20000000;
    localparam int          BIT_TIME_NS       = 666;
    localparam int          SIZE_W            = 7;
    localparam logic [6:0]  RECLAIM_SMALL     = 7'h20;
    localparam logic [6:0]  RECLAIM_LARGE     = 7'h40;
    localparam int          SOF_W             = 14;
    localparam int          EOP_BITS          = 3;
    // low-speed bit is 666 ns; cycles per bit rounded down, at least one
    localparam int          LS_BIT_CYC_RAW    = (BIT_TIME_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int          LS_BIT_CYC        = (LS_BIT_CYC_RAW < 1) ? 1 : LS_BIT_CYC_RAW;
    localparam int          EOP_CYC           = EOP_BITS * LS_BIT_CYC;
    localparam int          EOP_W             = 8;
    localparam logic [7:0]  EOP_LAST          = 8'(EOP_CYC - 1);
    typedef enum logic [1:0] {EOP_IDLE, EOP_SE0, EOP_J} eop_state_type;
endpackage

/* design/usb_eop_gen.sv */
// low-speed end-of-packet generator after global resume
`timescale 1ns/1ps
module usb_eop_gen (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic start,
    output logic      drive_se0,
    output logic      drive_j,
    output logic      busy
);
    usb_cmd_pkg::eop_state_type state_r, state_nxt;
    logic [7:0]                 cnt_r, cnt_nxt;

    // ************
    // next state
    // ************
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            usb_cmd_pkg::EOP_IDLE: begin
                if (start) begin
                    state_nxt = usb_cmd_pkg::EOP_SE0;
                    cnt_nxt   = '0;
                end
            end
            usb_cmd_pkg::EOP_SE0: begin
                if (cnt_r == usb_cmd_pkg::EOP_LAST) begin
                    state_nxt = usb_cmd_pkg::EOP_J;
                    cnt_nxt   = '0;
                end else begin
                    cnt_nxt = cnt_r + 8'h01;
                end
            end
            usb_cmd_pkg::EOP_J: begin
                if (cnt_r == 8'(usb_cmd_pkg::LS_BIT_CYC - 1)) begin
                    state_nxt = usb_cmd_pkg::EOP_IDLE;
                end else begin
                    cnt_nxt = cnt_r + 8'h01;
                end
            end
            default: state_nxt = usb_cmd_pkg::EOP_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= usb_cmd_pkg::EOP_IDLE;
            cnt_r   <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    assign drive_se0 = (state_r == usb_cmd_pkg::EOP_SE0);
    assign drive_j   = (state_r == usb_cmd_pkg::EOP_J);
    assign busy      = (state_r != usb_cmd_pkg::EOP_IDLE);
endmodule

/* design/usb_host_command_control.sv */
// usb host command register and its bus-level controls
`timescale 1ns/1ps
module usb_host_command_control (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [15:0] io_base,
    input  wire logic [15:0] io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [1:0]  io_be,
    input  wire logic [15:0] io_wdata,
    output logic [15:0]      io_rdata,
    output logic             io_hit,
    input  wire logic        resume_event_pin,
    input  wire logic        xact_done,
    input  wire logic [13:0] sof_remaining,
    input  wire logic [13:0] reclaim_time_cost,
    input  wire logic        reclaim_active,
    input  wire logic        end_window,
    input  wire logic [10:0] rx_byte_count,
    output logic             xact_start_ok,
    output logic             babble_error,
    output logic             stall_endpoint,
    output logic             controller_halted,
    output logic             drive_resume_k,
    output logic             drive_eop_se0,
    output logic             drive_eop_j,
    output logic             drive_bus_reset,
    output logic             logic_reset
);
    logic [7:0]  cmd_r, cmd_nxt;
    logic        halted_r, halted_nxt;
    logic        babble_r, babble_nxt;
    logic        stall_r, stall_nxt;
    logic        rsm_meta_r, rsm_sync_r;
    logic        bus_reset_seen_r, bus_reset_seen_nxt;
    logic        cmd_sel;
    logic        wr_lo;
    logic        eop_start;
    logic        eop_busy;
    logic        running;
    logic [6:0]  reclaim_size;
    logic [15:0] rdata_nxt;
    logic [15:0] rdata_r;
    logic [15:0] io_off;
    logic        eop_busy_d_r;
    logic        eop_busy_fall;

    // ************
    // address decode
    // ************
    assign io_off  = io_addr - io_base;
    assign cmd_sel = io_off[15:1] == usb_cmd_pkg::CMD_OFFSET[15:1];
    assign io_hit  = cmd_sel & (io_wr | io_rd);
    assign wr_lo   = cmd_sel & io_wr & io_be[0];

    // ************
    // resume pin synchroniser
    // ************
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rsm_meta_r <= 1'b0;
            rsm_sync_r <= 1'b0;
        end else begin
            rsm_meta_r <= resume_event_pin;
            rsm_sync_r <= rsm_meta_r;
        end
    end

    // ************
    // command register next value
    // ************
    always_comb begin
        cmd_nxt   = cmd_r;
        eop_start = 1'b0;
        if (wr_lo) begin
            cmd_nxt = io_wdata[7:0] & usb_cmd_pkg::CMD_WRITE_MASK[7:0];
            // one-to-zero write: bit stays one until the EOP finishes
            if (cmd_r[usb_cmd_pkg::BIT_FORCE_RESUME] &&
                !io_wdata[usb_cmd_pkg::BIT_FORCE_RESUME]) begin
                cmd_nxt[usb_cmd_pkg::BIT_FORCE_RESUME] = 1'b1;
                eop_start = !eop_busy;
            end
        end
        if (cmd_r[usb_cmd_pkg::BIT_FORCE_RESUME] && eop_busy_fall) begin
            cmd_nxt[usb_cmd_pkg::BIT_FORCE_RESUME] = 1'b0;
        end
        // single step: drop run/stop when a transaction completes
        if (cmd_r[usb_cmd_pkg::BIT_SINGLE_STEP] && running && xact_done) begin
            cmd_nxt[usb_cmd_pkg::BIT_RUN_STOP] = 1'b0;
        end
        // hardware set wins over a software clear
        if (cmd_r[usb_cmd_pkg::BIT_SUSPEND] && rsm_sync_r && !eop_busy) begin
            cmd_nxt[usb_cmd_pkg::BIT_FORCE_RESUME] = 1'b1;
        end
    end

    assign eop_busy_fall = eop_busy_d_r & !eop_busy;

    always_ff @(posedge clk_sys) begin
        if (reset || logic_reset) begin
            cmd_r        <= usb_cmd_pkg::CMD_RESET[7:0];
            eop_busy_d_r <= 1'b0;
        end else begin
            cmd_r        <= cmd_nxt;
            eop_busy_d_r <= eop_busy;
        end
    end

    // ************
    // low-speed EOP
    // ************
    usb_eop_gen u_eop (
        .clk_sys   (clk_sys),
        .reset     (reset | logic_reset),
        .start     (eop_start),
        .drive_se0 (drive_eop_se0),
        .drive_j   (drive_eop_j),
        .busy      (eop_busy)
    );

    // ************
    // bus signalling
    // ************
    assign drive_resume_k  = cmd_r[usb_cmd_pkg::BIT_FORCE_RESUME] &
                             !eop_busy & !eop_busy_d_r;
    assign drive_bus_reset = cmd_r[usb_cmd_pkg::BIT_BUS_RESET];

    // logic reset pulses once when global reset is released
    always_comb begin
        bus_reset_seen_nxt = cmd_r[usb_cmd_pkg::BIT_BUS_RESET];
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bus_reset_seen_r <= 1'b0;
        end else begin
            bus_reset_seen_r <= bus_reset_seen_nxt;
        end
    end

    assign logic_reset = bus_reset_seen_r & !cmd_r[usb_cmd_pkg::BIT_BUS_RESET];

    // ************
    // schedule gating and reclamation
    // ************
    assign running = cmd_r[usb_cmd_pkg::BIT_RUN_STOP] &
                     !cmd_r[usb_cmd_pkg::BIT_SUSPEND] &
                     !cmd_r[usb_cmd_pkg::BIT_BUS_RESET];
    assign reclaim_size = cmd_r[usb_cmd_pkg::BIT_RECLAIM_SEL] ?
                          usb_cmd_pkg::RECLAIM_LARGE : usb_cmd_pkg::RECLAIM_SMALL;
    assign xact_start_ok = running & !halted_r &
                           (!reclaim_active || (reclaim_time_cost <= sof_remaining));

    always_comb begin
        halted_nxt = halted_r;
        babble_nxt = 1'b0;
        stall_nxt  = 1'b0;
        // halt once the current transaction is done, or in the next cycle if run/stop is clear
        if (running) begin
            halted_nxt = 1'b0;
        end else if (xact_done || halted_r || !cmd_r[usb_cmd_pkg::BIT_RUN_STOP]) begin
            halted_nxt = 1'b1;
        end
        if (reclaim_active && end_window && xact_done &&
            (rx_byte_count > {4'h0, reclaim_size})) begin
            babble_nxt = 1'b1;
            stall_nxt  = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || logic_reset) begin
            halted_r <= 1'b1;
            babble_r <= 1'b0;
            stall_r  <= 1'b0;
        end else begin
            halted_r <= halted_nxt;
            babble_r <= babble_nxt;
            stall_r  <= stall_nxt;
        end
    end

    assign babble_error      = babble_r;
    assign stall_endpoint    = stall_r;
    assign controller_halted = halted_r;

    // ************
    // read data
    // ************
    always_comb begin
        rdata_nxt = 16'h0000;
        if (cmd_sel && io_rd) begin
            rdata_nxt = {8'h00, cmd_r};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign io_rdata = rdata_r;
endmodule

/* tb/tb_usb_host_command_control.sv */
// self-checking bench of the usb host command register block
`timescale 1ns/1ps
module tb_usb_host_command_control;
    logic        clk_sys, reset, io_wr, io_rd, resume_event_pin, xact_done, seen;
    logic        reclaim_active, end_window, wake, io_hit, xact_start_ok, babble_error;
    logic        stall_endpoint, controller_halted, drive_resume_k, drive_eop_se0;
    logic        drive_eop_j, drive_bus_reset, logic_reset;
    logic [1:0]  io_be;
    logic [15:0] io_base, io_addr, io_wdata, io_rdata;
    logic [13:0] sof_remaining, reclaim_time_cost;
    logic [10:0] rx_byte_count;
    int          n_fail = 0, compares = 0, se0_len, j_len, i;
    usb_host_command_control dut_u (.clk_sys, .reset, .io_base, .io_addr, .io_wr, .io_rd,
        .io_be, .io_wdata, .io_rdata, .io_hit, .resume_event_pin, .xact_done,
        .sof_remaining, .reclaim_time_cost, .reclaim_active, .end_window, .rx_byte_count,
        .xact_start_ok, .babble_error, .stall_endpoint, .controller_halted,
        .drive_resume_k, .drive_eop_se0, .drive_eop_j, .drive_bus_reset, .logic_reset);
    usb_device_model dev_u (.clk_sys, .wake, .drive_eop_se0, .drive_eop_j, .resume_event_pin,
        .se0_len, .j_len);
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic wr(input logic [15:0] d);
        @(posedge clk_sys);
        io_wr <= 1'b1;
        io_wdata <= d;
        io_addr <= io_base;
        @(posedge clk_sys);
        io_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] off, input logic [15:0] exp);
        @(posedge clk_sys);
        io_rd <= 1'b1;
        io_addr <= io_base + off;
        #1 chkb(io_hit, off < 16'h0002);
        @(posedge clk_sys);
        io_rd <= 1'b0;
        #1 chk(io_rdata, exp);
    endtask
    task automatic watch_babble(input logic b);
        logic st;
        @(posedge clk_sys);
        xact_done <= 1'b1;
        @(posedge clk_sys);
        xact_done <= 1'b0;
        seen = 1'b0;
        st = 1'b0;
        repeat (4) begin
            #1 seen |= babble_error;
            st |= stall_endpoint;
            @(posedge clk_sys);
        end
        chkb(seen, b);
        chkb(st, b);
    endtask
    task automatic wait_halt(input logic v);
        #1;
        for (i = 0; i < 100 && controller_halted !== v; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chkb(controller_halted, v);
        if (i == 100) end_sim();
    endtask
    initial begin
        reset = 1'b1;
        {io_wr, io_rd, xact_done, reclaim_active, end_window, wake} = 6'h00;
        {io_be, io_base, io_addr, io_wdata} = {2'h3, 16'hc000, 16'hc000, 16'h0000};
        {sof_remaining, reclaim_time_cost} = {14'h0064, 14'h0032};
        rx_byte_count = 11'h000;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        rd(16'h0000, 16'h0000);
        chkb(controller_halted, 1'b1);
        wr(16'hffc0);
        rd(16'h0000, 16'h00c0);
        rd(16'h0004, 16'h0000);
        $display("test registers done");
        wr(16'h0001);
        wait_halt(1'b0);
        chkb(xact_start_ok, 1'b1);
        @(posedge clk_sys);
        {sof_remaining, reclaim_active} <= {14'h000a, 1'b1};
        @(posedge clk_sys);
        #1 chkb(xact_start_ok, 1'b0);
        {sof_remaining, end_window, reclaim_active} <= {14'h0064, 2'h3};
        rx_byte_count <= 11'h021;
        watch_babble(1'b1);
        wr(16'h0081);
        watch_babble(1'b0);
        rx_byte_count <= 11'h041;
        watch_babble(1'b1);
        end_window <= 1'b0;
        watch_babble(1'b0);
        $display("test reclamation done");
        wr(16'h0000);
        watch_babble(1'b0);
        wait_halt(1'b1);
        wr(16'h0020);
        wr(16'h0021);
        wait_halt(1'b0);
        watch_babble(1'b0);
        rd(16'h0000, 16'h0020);
        wait_halt(1'b1);
        $display("test single step done");
        wr(16'h0008);
        rd(16'h0000, 16'h0008);
        chkb(xact_start_ok, 1'b0);
        wake <= 1'b1;
        @(posedge clk_sys);
        wake <= 1'b0;
        for (i = 0; i < 100 && drive_resume_k !== 1'b1; i++) @(posedge clk_sys);
        chkb(drive_resume_k, 1'b1);
        if (i == 100) end_sim();
        rd(16'h0000, 16'h0018);
        chkb(drive_resume_k, 1'b1);
        wr(16'h0000);
        rd(16'h0000, 16'h0010);
        repeat (54) @(posedge clk_sys);
        rd(16'h0000, 16'h0000);
        chk(16'(se0_len), 16'h0027);
        chk(16'(j_len), 16'h000d);
        $display("test suspend resume done");
        wr(16'h0044);
        rd(16'h0000, 16'h0044);
        chkb(drive_bus_reset, 1'b1);
        wr(16'h0040);
        seen = 1'b0;
        repeat (4) begin
            #1 seen |= logic_reset;
            @(posedge clk_sys);
        end
        chkb(seen, 1'b1);
        rd(16'h0000, 16'h0000);
        $display("test global reset done");
        end_sim();
    end
endmodule

/* tb/usb_cmd_properties.sv */
// assertions on the usb host command register ports
`timescale 1ns/1ps
module usb_cmd_properties (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic [15:0] io_base,
    input wire logic [15:0] io_addr,
    input wire logic        io_rd,
    input wire logic [15:0] io_rdata,
    input wire logic        io_hit,
    input wire logic        babble_error,
    input wire logic        stall_endpoint,
    input wire logic        drive_resume_k,
    input wire logic        drive_eop_se0,
    input wire logic        drive_eop_j,
    input wire logic        drive_bus_reset,
    input wire logic        logic_reset
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_upper_byte_zero: assert property (io_rdata[15:8] == 8'h00)
        else $error("upper byte not zero");
    a_rdata_idle: assert property (!$past(io_rd) |-> io_rdata == 16'h0000)
        else $error("read data without read");
    a_unmapped_no_hit: assert property (16'(io_addr - io_base) > 16'h0001 |-> !io_hit)
        else $error("hit outside block");
    a_eop_se0_hold: assert property ($rose(drive_eop_se0) |-> drive_eop_se0 [*8])
        else $error("eop se0 too short");
    a_eop_j_follows: assert property ($fell(drive_eop_se0) |-> drive_eop_j)
        else $error("no j after se0");
    a_resume_no_eop: assert property (drive_resume_k |-> !drive_eop_se0 && !drive_eop_j)
        else $error("resume k during eop");
    a_no_k_after_eop: assert property ($fell(drive_eop_j) |-> !drive_resume_k)
        else $error("resume k right after eop");
    a_babble_stalls: assert property (babble_error |-> ##[0:1] stall_endpoint)
        else $error("babble without stall");
    a_bus_reset_end: assert property ($fell(drive_bus_reset) |-> ##[0:1] logic_reset)
        else $error("no logic reset after bus reset");
    c_eop_done: cover property ($fell(drive_eop_j));
    c_babble: cover property (babble_error);
    c_logic_reset: cover property (logic_reset);
endmodule
bind usb_host_command_control usb_cmd_properties chk_u (.clk_sys, .reset, .io_base,
    .io_addr, .io_rd, .io_rdata, .io_hit, .babble_error, .stall_endpoint, .drive_resume_k,
    .drive_eop_se0, .drive_eop_j, .drive_bus_reset, .logic_reset);

/* tb/usb_device_model.sv */
// usb device on the bus: resume k-state and eop length probe
`timescale 1ns/1ps
module usb_device_model (
    input  wire logic clk_sys,
    input  wire logic wake,
    input  wire logic drive_eop_se0,
    input  wire logic drive_eop_j,
    output logic      resume_event_pin,
    output int        se0_len,
    output int        j_len
);
    int k_cnt = 0;
    int run = 0;
    int j_run = 0;
    initial se0_len = 0;
    initial j_len = 0;
    always @(posedge clk_sys) begin
        if (wake)
            k_cnt <= 20;
        else if (k_cnt > 0)
            k_cnt <= k_cnt - 1;
        if (drive_eop_se0)
            run <= run + 1;
        else if (run > 0) begin
            se0_len <= run;
            run <= 0;
        end
        if (drive_eop_j)
            j_run <= j_run + 1;
        else if (j_run > 0) begin
            j_len <= j_run;
            j_run <= 0;
        end
    end
    assign resume_event_pin = (k_cnt > 0);
endmodule
